// *** core/cps_cfg.svh ***
// What this block does
// - Three capture prescalers (1, 4, 16) chosen by mode field
// - Prescaler counter zero when off or in a non-capture mode
// - Every reset clears the prescaler counter
// - Prescaler change between capture modes keeps counter
// - Sixteen-bit timer is the capture time base
// - Timer clocked by four selectable sources
// - Internal-clocked timer stops counting during sleep
// - Timer resumes from held value after wake
// - External-clocked timer keeps capturing during sleep
// - Captured value shown as high and low bytes
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH

`define CPS_MODE_W          4
`define CPS_MODE_OFF        4'h0
`define CPS_MODE_FALL_1     4'h4
`define CPS_MODE_RISE_1     4'h5
`define CPS_MODE_RISE_4     4'h6
`define CPS_MODE_RISE_16    4'h7

`define CPS_PRE_W           4
`define CPS_PRE_RST         4'h0
`define CPS_PRE_ONE         4'h1
`define CPS_PRE_LAST_1      4'h0
`define CPS_PRE_LAST_4      4'h3
`define CPS_PRE_LAST_16     4'hf

`define CPS_TMR_W           16
`define CPS_TMR_RST         16'h0000
`define CPS_TMR_ONE         16'h0001
`define CPS_BYTE_W          8
`define CPS_BYTE_RST        8'h00
`define CPS_HI_MSB          15
`define CPS_HI_LSB          8
`define CPS_LO_MSB          7
`define CPS_LO_LSB          0

`define CPS_DIV_W           2
`define CPS_DIV_RST         2'h0
`define CPS_DIV_ONE         2'h1
`define CPS_DIV_LAST        2'h3

`define CPS_SRC_W           2
`define CPS_NUM_PINS        3
`define CPS_PIN_CAPT        0
`define CPS_PIN_TCKI        1
`define CPS_PIN_SOSC        2

`endif

// *** core/cps_pkg.sv ***
`include "cps_cfg.svh"
package cps_pkg;
  typedef logic [`CPS_MODE_W-1:0] cps_mode_t;
  typedef logic [`CPS_PRE_W-1:0]  cps_pre_t;
  typedef logic [`CPS_TMR_W-1:0]  cps_count_t;
  typedef logic [`CPS_BYTE_W-1:0] cps_byte_t;
  typedef logic [`CPS_DIV_W-1:0]  cps_div_t;

  // Declaration order gives the 2-bit source field encoding 0..3
  typedef enum logic [`CPS_SRC_W-1:0] {
    CPS_SRC_FOSC,
    CPS_SRC_INSTR,
    CPS_SRC_SOSC,
    CPS_SRC_TCKI
  } cps_src_e;
endpackage

// *** core/cps_timebase.sv ***
`timescale 1ns/1ps
`include "cps_cfg.svh"
module cps_timebase
  import cps_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Control
  input  wire cps_src_e   src,
  input  wire logic       run,
  input  wire logic       sleep,
  // Synchronised external clock edges
  input  wire logic       sosc_rise,
  input  wire logic       tcki_rise,
  // Count
  output cps_count_t      count,
  output logic            internal_src
);

  cps_div_t   div_q;
  cps_div_t   div_d;
  cps_count_t count_q;
  cps_count_t count_d;
  logic       tick;

  assign internal_src = (src == CPS_SRC_FOSC) || (src == CPS_SRC_INSTR);
  assign count        = count_q;

  always_comb begin
    div_d = div_q;
    tick  = 1'b0;
    case (src)
      CPS_SRC_FOSC:  tick = ~sleep;
      CPS_SRC_INSTR: begin
        // Divider freezes in sleep so the phase is kept on wake
        if (!sleep) begin
          div_d = div_q + `CPS_DIV_ONE;
          tick  = (div_q == `CPS_DIV_LAST);
        end
      end
      CPS_SRC_SOSC:  tick = sosc_rise;
      CPS_SRC_TCKI:  tick = tcki_rise;
      default:       tick = 1'b0;
    endcase
  end

  always_comb begin
    count_d = count_q;
    // No reset on wake; the count simply resumes from where it stopped
    if (run && tick) begin
      count_d = count_q + `CPS_TMR_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q   <= `CPS_DIV_RST;
      count_q <= `CPS_TMR_RST;
    end else if (ce) begin
      div_q   <= div_d;
      count_q <= count_d;
    end
  end

endmodule

// *** core/cps_top.sv ***
`timescale 1ns/1ps
`include "cps_cfg.svh"
module cps_top
  import cps_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       CLK_EN,
  // Capture control
  input  wire cps_mode_t  CAPTURE_MODE_SELECT,
  input  wire logic [1:0] CLOCK_SOURCE_SELECT,
  input  wire logic       TIMER_ON,
  input  wire logic       SLEEP,
  input  wire logic       FLAG_CLEAR,
  // Pins
  input  wire logic       CAPTURE_PIN,
  input  wire logic       TIMER_EXT_CLOCK_INPUT,
  input  wire logic       SECONDARY_OSC_INPUT,
  // Results
  output cps_byte_t       CAPTURE_VALUE_HIGH,
  output cps_byte_t       CAPTURE_VALUE_LOW,
  output logic            CAPTURE_EVENT_FLAG,
  output cps_count_t      TIMER_COUNT
);

  // Modes that count input edges through the prescaler
  function automatic logic is_capture_mode(input cps_mode_t m);
    is_capture_mode = (m == `CPS_MODE_FALL_1)  ||
                      (m == `CPS_MODE_RISE_1)  ||
                      (m == `CPS_MODE_RISE_4)  ||
                      (m == `CPS_MODE_RISE_16);
  endfunction

  // Last count value before a capture fires, per mode
  function automatic cps_pre_t pre_last(input cps_mode_t m);
    case (m)
      `CPS_MODE_RISE_4:  pre_last = `CPS_PRE_LAST_4;
      `CPS_MODE_RISE_16: pre_last = `CPS_PRE_LAST_16;
      default:           pre_last = `CPS_PRE_LAST_1;
    endcase
  endfunction

  // Two-stage synchronisers plus a history stage for edge detection
  // History resets low to match an idle pin; a pin that idles high would
  // show one false rising edge after reset
  logic [`CPS_NUM_PINS-1:0] pin_in;
  logic [`CPS_NUM_PINS-1:0] meta_q;
  logic [`CPS_NUM_PINS-1:0] meta_d;
  logic [`CPS_NUM_PINS-1:0] sync_q;
  logic [`CPS_NUM_PINS-1:0] sync_d;
  logic [`CPS_NUM_PINS-1:0] hist_q;
  logic [`CPS_NUM_PINS-1:0] hist_d;
  logic [`CPS_NUM_PINS-1:0] rise;
  logic [`CPS_NUM_PINS-1:0] fall;

  assign pin_in[`CPS_PIN_CAPT] = CAPTURE_PIN;
  assign pin_in[`CPS_PIN_TCKI] = TIMER_EXT_CLOCK_INPUT;
  assign pin_in[`CPS_PIN_SOSC] = SECONDARY_OSC_INPUT;

  genvar gi;
  generate
    for (gi = 0; gi < `CPS_NUM_PINS; gi = gi + 1) begin : g_sync
      always_comb begin
        meta_d[gi] = pin_in[gi];
        sync_d[gi] = meta_q[gi];
        hist_d[gi] = sync_q[gi];
        rise[gi]   = sync_q[gi] & ~hist_q[gi];
        fall[gi]   = ~sync_q[gi] & hist_q[gi];
      end

      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          hist_q[gi] <= 1'b0;
        end else if (CLK_EN) begin
          meta_q[gi] <= meta_d[gi];
          sync_q[gi] <= sync_d[gi];
          hist_q[gi] <= hist_d[gi];
        end
      end
    end
  endgenerate

  // Time base
  cps_src_e   src;
  cps_count_t tmr_count;
  logic       tmr_internal;

  assign src = cps_src_e'(CLOCK_SOURCE_SELECT);

  cps_timebase u_timebase (
    .clk          (CLK),
    .rst          (SYS_RST),
    .ce           (CLK_EN),
    .src          (src),
    .run          (TIMER_ON),
    .sleep        (SLEEP),
    .sosc_rise    (rise[`CPS_PIN_SOSC]),
    .tcki_rise    (rise[`CPS_PIN_TCKI]),
    .count        (tmr_count),
    .internal_src (tmr_internal)
  );

  // Prescaler and capture
  cps_pre_t   pre_q;
  cps_pre_t   pre_d;
  cps_byte_t  hi_q;
  cps_byte_t  hi_d;
  cps_byte_t  lo_q;
  cps_byte_t  lo_d;
  logic       flag_q;
  logic       flag_d;
  cps_count_t cnt_q;
  cps_count_t cnt_d;
  logic       capt_mode;
  logic       capt_active;
  logic       edge_seen;
  logic       fire;
  cps_pre_t   pre_limit;
  cps_byte_t  count_hi;
  cps_byte_t  count_lo;

  assign capt_mode = is_capture_mode(CAPTURE_MODE_SELECT);
  assign pre_limit = pre_last(CAPTURE_MODE_SELECT);
  assign count_hi  = tmr_count[`CPS_HI_MSB:`CPS_HI_LSB];
  assign count_lo  = tmr_count[`CPS_LO_MSB:`CPS_LO_LSB];

  // With an internal source the capture logic is asleep too; only the
  // external sources keep the unit capturing through sleep
  assign capt_active = capt_mode && !(SLEEP && tmr_internal);

  always_comb begin
    edge_seen = 1'b0;
    case (CAPTURE_MODE_SELECT)
      `CPS_MODE_FALL_1:  edge_seen = fall[`CPS_PIN_CAPT];
      `CPS_MODE_RISE_1,
      `CPS_MODE_RISE_4,
      `CPS_MODE_RISE_16: edge_seen = rise[`CPS_PIN_CAPT];
      default:           edge_seen = 1'b0;
    endcase
  end

  always_comb begin
    pre_d = pre_q;
    fire  = 1'b0;
    if (!capt_mode) begin
      pre_d = `CPS_PRE_RST;
    end else if (capt_active && edge_seen) begin
      // Switching to a smaller prescaler leaves the old count in place;
      // the >= compare then fires early, which is the false capture that
      // software avoids by turning the unit off first
      if (pre_q >= pre_limit) begin
        fire  = 1'b1;
        pre_d = `CPS_PRE_RST;
      end else begin
        pre_d = pre_q + `CPS_PRE_ONE;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pre_q <= `CPS_PRE_RST;
    end else if (CLK_EN) begin
      pre_q <= pre_d;
    end
  end

  // Capture registers and flag
  always_comb begin
    hi_d   = hi_q;
    lo_d   = lo_q;
    flag_d = flag_q;
    if (FLAG_CLEAR) begin
      flag_d = 1'b0;
    end
    // Set wins over a clear in the same cycle, so an event is never lost
    // while software is acknowledging the previous one
    if (fire) begin
      hi_d   = count_hi;
      lo_d   = count_lo;
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      hi_q   <= `CPS_BYTE_RST;
      lo_q   <= `CPS_BYTE_RST;
      flag_q <= 1'b0;
    end else if (CLK_EN) begin
      hi_q   <= hi_d;
      lo_q   <= lo_d;
      flag_q <= flag_d;
    end
  end

  // Registered copy of the count, one cycle behind the live counter
  always_comb begin
    cnt_d = tmr_count;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cnt_q <= `CPS_TMR_RST;
    end else if (CLK_EN) begin
      cnt_q <= cnt_d;
    end
  end

  assign CAPTURE_VALUE_HIGH = hi_q;
  assign CAPTURE_VALUE_LOW  = lo_q;
  assign CAPTURE_EVENT_FLAG = flag_q;
  assign TIMER_COUNT        = cnt_q;

endmodule

// *** dv/cps_checker.sv ***
`timescale 1ns/1ps
`include "cps_cfg.svh"
module cps_checker
  import cps_pkg::*;
(
  // Clock and reset
  input wire logic       CLK,
  input wire logic       SYS_RST,
  // Controls and pin
  input wire logic       CLK_EN,
  input wire cps_mode_t  CAPTURE_MODE_SELECT,
  input wire logic [1:0] CLOCK_SOURCE_SELECT,
  input wire logic       TIMER_ON,
  input wire logic       SLEEP,
  input wire logic       FLAG_CLEAR,
  input wire logic       CAPTURE_PIN,
  // Results
  input wire cps_byte_t  CAPTURE_VALUE_HIGH,
  input wire cps_byte_t  CAPTURE_VALUE_LOW,
  input wire logic       CAPTURE_EVENT_FLAG,
  input wire cps_count_t TIMER_COUNT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic go;
  assign go = CLK_EN && !SLEEP;
  sequence s_rise;
    CAPTURE_MODE_SELECT == `CPS_MODE_RISE_1 && go && $rose(CAPTURE_PIN);
  endsequence
  sequence s_keep;
    (CAPTURE_MODE_SELECT == `CPS_MODE_RISE_1 && go)[*2];
  endsequence
  AST_RST_CLEAR: assert property (disable iff (1'b0) SYS_RST |=> !CAPTURE_EVENT_FLAG && TIMER_COUNT == '0
    && CAPTURE_VALUE_HIGH == '0 && CAPTURE_VALUE_LOW == '0) else $error("reset left state");
  AST_SLEEP_FREEZE: assert property ((SLEEP && !CLOCK_SOURCE_SELECT[1])[*2] |=> $stable(TIMER_COUNT))
    else $error("timer moved in sleep");
  AST_FOSC_STEP: assert property ((CLOCK_SOURCE_SELECT == 2'h0 && go && TIMER_ON)[*2] |=>
    TIMER_COUNT == cps_count_t'($past(TIMER_COUNT) + 1'b1)) else $error("fast step");
  AST_INSTR_STEP: assert property ((CLOCK_SOURCE_SELECT == 2'h1 && go && TIMER_ON)[*8] |->
    TIMER_COUNT == cps_count_t'($past(TIMER_COUNT, 4) + 1'b1)) else $error("quarter step");
  AST_FLAG_STICKY: assert property (CAPTURE_EVENT_FLAG && !FLAG_CLEAR |=> CAPTURE_EVENT_FLAG)
    else $error("flag dropped");
  AST_OFF_QUIET: assert property ((CAPTURE_MODE_SELECT[3:2] != 2'b01)[*2] |=>
    !$rose(CAPTURE_EVENT_FLAG) && $stable({CAPTURE_VALUE_HIGH, CAPTURE_VALUE_LOW})) else $error("capture when off");
  AST_CAPTURE_VALUE: assert property ($rose(CAPTURE_EVENT_FLAG) |->
    {CAPTURE_VALUE_HIGH, CAPTURE_VALUE_LOW} == TIMER_COUNT) else $error("captured value");
  AST_CAPTURE_LATENCY: assert property (s_rise ##1 s_keep |=> CAPTURE_EVENT_FLAG)
    else $error("edge not captured");
endmodule
bind cps_top cps_checker i_chk (.CLK, .SYS_RST, .CLK_EN, .CAPTURE_MODE_SELECT, .CLOCK_SOURCE_SELECT,
  .TIMER_ON, .SLEEP, .FLAG_CLEAR, .CAPTURE_PIN, .CAPTURE_VALUE_HIGH, .CAPTURE_VALUE_LOW,
  .CAPTURE_EVENT_FLAG, .TIMER_COUNT);

// *** dv/cps_edge_src.sv ***
`timescale 1ns/1ps
`include "cps_cfg.svh"
module cps_edge_src (
  // Clock
  input  wire logic clk,
  // Pins into the capture unit
  output logic      capt_pin,
  output logic      tcki_pin,
  output logic      sosc_pin
);
  logic [2:0] lvl = 3'h0;
  assign capt_pin = lvl[`CPS_PIN_CAPT];
  assign tcki_pin = lvl[`CPS_PIN_TCKI];
  assign sosc_pin = lvl[`CPS_PIN_SOSC];
  // Three cycles a level, so every edge outlasts the two-flop synchronisers
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge clk);
      lvl[sel] <= 1'b1;
      repeat (3) @(posedge clk);
      lvl[sel] <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

// *** dv/capture_prescaler_sleep_tb_top.sv ***
`timescale 1ns/1ps
`include "cps_cfg.svh"
module capture_prescaler_sleep_tb_top
  import cps_pkg::*;
;
  typedef struct {cps_mode_t m; int n; logic f;} cps_row_s;
  // Mode, rising pulses, flag expected
  cps_row_s rows[8] = '{'{4'h5, 1, 1}, '{4'h4, 1, 1}, '{4'h6, 3, 0}, '{4'h6, 4, 1},
                        '{4'h7, 15, 0}, '{4'h7, 16, 1}, '{4'h0, 4, 0}, '{4'h3, 4, 0}};
  logic       clk = 1'b0, rst = 1'b1, slp = 1'b0, fclr = 1'b0, ce = 1'b1;
  cps_mode_t  mode = 4'h0;
  logic [1:0] src = 2'h0;
  logic       cpin, tpin, spin, flag;
  cps_byte_t  hi, lo;
  cps_count_t tcnt, held;
  int         miscompares = 0, checks_done = 0, cycles = 0;
  cps_edge_src i_ext (.clk(clk), .capt_pin(cpin), .tcki_pin(tpin), .sosc_pin(spin));
  cps_top i_dut (.CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .CAPTURE_MODE_SELECT(mode),
    .CLOCK_SOURCE_SELECT(src), .TIMER_ON(1'b1), .SLEEP(slp), .FLAG_CLEAR(fclr), .CAPTURE_PIN(cpin),
    .TIMER_EXT_CLOCK_INPUT(tpin), .SECONDARY_OSC_INPUT(spin), .CAPTURE_VALUE_HIGH(hi),
    .CAPTURE_VALUE_LOW(lo), .CAPTURE_EVENT_FLAG(flag), .TIMER_COUNT(tcnt));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      $display("Error %0t: timeout", $time);
      print_verdict();
    end
  end
  task automatic chk16(input cps_count_t got, input cps_count_t exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Unit off for one cycle between settings, so no stale prescaler count survives
  task automatic restart(input cps_mode_t m);
    @(posedge clk);
    mode <= 4'h0;
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    mode <= m;
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      restart(rows[i].m);
      i_ext.pulse(`CPS_PIN_CAPT, rows[i].n);
      settle(4);
      chk1(flag, rows[i].f);
    end
    restart(`CPS_MODE_RISE_16);
    i_ext.pulse(`CPS_PIN_CAPT, 4);
    @(posedge clk);
    mode <= `CPS_MODE_RISE_4;
    i_ext.pulse(`CPS_PIN_CAPT, 1);
    settle(4);
    chk1(flag, 1'b1);
    // A non-capture code between settings must drop the stale count
    restart(`CPS_MODE_RISE_16);
    i_ext.pulse(`CPS_PIN_CAPT, 4);
    @(posedge clk);
    mode <= 4'h3;
    @(posedge clk);
    mode <= `CPS_MODE_RISE_4;
    i_ext.pulse(`CPS_PIN_CAPT, 1);
    settle(4);
    chk1(flag, 1'b0);
    restart(`CPS_MODE_RISE_4);
    i_ext.pulse(`CPS_PIN_CAPT, 2);
    @(posedge clk);
    rst <= 1'b1;
    settle(2);
    chk16(tcnt, 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    i_ext.pulse(`CPS_PIN_CAPT, 2);
    settle(4);
    chk1(flag, 1'b0);
    restart(`CPS_MODE_RISE_1);
    @(posedge clk);
    slp <= 1'b1;
    settle(3);
    held = tcnt;
    i_ext.pulse(`CPS_PIN_CAPT, 1);
    settle(4);
    chk16(tcnt, held);
    chk1(flag, 1'b0);
    @(posedge clk);
    slp <= 1'b0;
    settle(3);
    chk16(tcnt, held + 16'h0002);
    for (int s = 1; s < 4; s++) begin
      @(posedge clk);
      src <= 2'(s);
      slp <= 1'b1;
      restart(`CPS_MODE_RISE_1);
      settle(0);
      held = tcnt;
      i_ext.pulse(s == 2 ? `CPS_PIN_SOSC : `CPS_PIN_TCKI, 3);
      settle(4);
      chk16(tcnt, held + (s == 1 ? 16'h0000 : 16'h0003));
      i_ext.pulse(`CPS_PIN_CAPT, 1);
      settle(4);
      chk1(flag, s != 1);
      if (s != 1) chk16({hi, lo}, held + 16'h0003);
    end
    @(posedge clk);
    src <= 2'h1;
    slp <= 1'b0;
    settle(12);
    // Clock enable low freezes the time base and its copy
    @(posedge clk);
    ce <= 1'b0;
    settle(2);
    held = tcnt;
    settle(4);
    chk16(tcnt, held);
    print_verdict();
  end
endmodule
